/* rtl/acs_pkg.sv */
// Purpose: shared constants and types of the conversion sequencer
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: all timing counts are in main-clock cycles
package acs_pkg;
	localparam int unsigned NCH = 8;
	localparam int unsigned CHW = 3;
	localparam int unsigned DW = 24;
	localparam int unsigned FWW = 7;
	localparam int unsigned ACCW = 12;
	localparam int unsigned CW = 16;
	// control group, byte offsets
	localparam logic [4:0] A_MODE = 5'h00;
	localparam logic [4:0] A_IOPORT = 5'h04;
	localparam logic [4:0] A_ADCSTAT = 5'h08;
	localparam logic [4:0] A_IRQSTAT = 5'h0C;
	localparam logic [4:0] A_IRQMASK = 5'h10;
	// per-channel groups: paddr[7:5] selects group, paddr[4:2] the channel
	localparam logic [2:0] G_CTRL = 3'h0;
	localparam logic [2:0] G_SETUP = 3'h2;
	localparam logic [2:0] G_OFFS = 3'h3;
	localparam logic [2:0] G_DATA = 3'h4;
	localparam logic [2:0] G_CHSTAT = 3'h5;
	// field positions
	localparam int unsigned MODE_CH_LSB = 4;
	localparam int unsigned SU_EN = 0;
	localparam int unsigned SU_DIFF = 1;
	localparam int unsigned SU_CHOP = 2;
	localparam int unsigned SU_FW_LSB = 8;
	localparam int unsigned CHST_RDY = 3;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_OVWR = 1;
	// operating modes
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h1;
	localparam logic [1:0] MODE_SINGLE = 2'h2;
	// timing in main-clock cycles
	localparam logic [CW-1:0] SETTLE1_LONG = 16'h002C;
	localparam logic [CW-1:0] SETTLE1_SHORT = 16'h002B;
	localparam logic [CW-1:0] SETTLE2_CYC = 16'h002A;
	localparam logic [CW-1:0] SCALE_CYC = 16'h00A3;
	localparam int unsigned FW_TICK_SHIFT = 4; // modulator ticks per filter_word unit, as a shift
	localparam int unsigned MOD_DIV_SHIFT = 1; // modulator runs at half the main clock
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETTLE1 = 3'b001,
		ST_SAMPLE1 = 3'b010,
		ST_SETTLE2 = 3'b011,
		ST_SAMPLE2 = 3'b100,
		ST_SCALE = 3'b101
	} acs_state_t;
	typedef struct packed {
		logic [CHW-1:0] ch;
		logic diff;
		logic swap;
		logic sampling;
	} acs_mux_t;
	typedef struct packed {
		logic [FWW-1:0] fw;
		logic chop;
		logic diff;
		logic en;
	} acs_setup_t;
endpackage

/* rtl/acs_sequencer.sv */
// Purpose: conversion-cycle sequencer with APB register file and interrupt
// Assumes: mod_bit comes from on-chip modulator logic on clk_sys
// Notes: filter is a ones counter; calibration is an offset subtract
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
//Contract
//- chop on: polarity swaps between the two sampling phases
//- chop on: result is mean of normal and reversed phase results
//- each cycle opens with 43 or 44 cycles of settling
//- sampling length follows the channel filter_word
//- chop on: 42-cycle second settle, then reversed sampling phase
//- 163-cycle scaling combines, calibrates, stores to data register
//- chop off: one settle, one sampling, one scaling phase
//- ready pin high throughout scaling
//- at update end set both ready bits and pull ready pin low, in all-enabled select only once every enabled channel is ready
//- continuous mode starts next enabled channel immediately
//- each channel uses its own timing and chop settings
//- modulator clocked at half main clock
//- mux routes each channel single-ended or differential
//- single conversion returns mode to idle after storing
//- continuous scan runs until mode written or reset
//- reading a data register clears its ready bit
//- ready_all_select picks all-enabled or any-channel ready pin
module acs_sequencer (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mod_bit,
	output acs_pkg::acs_mux_t mux,
	output logic mod_clk,
	output logic ready_n,
	output logic irq
);
	import acs_pkg::*;

	logic [1:0] mode_reg, mode_next;
	logic [CHW-1:0] sel_ch_reg, sel_ch_next;
	logic rall_reg, rall_next;
	acs_setup_t setup_reg [NCH];
	acs_setup_t setup_next [NCH];
	logic [DW-1:0] offs_reg [NCH];
	logic [DW-1:0] offs_next [NCH];
	logic [DW-1:0] data_reg [NCH];
	logic [DW-1:0] data_next [NCH];
	logic [NCH-1:0] rdy_reg, rdy_next;
	logic [1:0] irqst_reg, irqst_next;
	logic [1:0] irqmask_reg, irqmask_next;
	acs_state_t state_reg, state_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [CHW-1:0] cur_reg, cur_next;
	logic [ACCW-1:0] acc_reg, acc_next;
	logic [ACCW-1:0] acc1_reg, acc1_next;
	logic first_reg, first_next;
	acs_mux_t mux_reg, mux_next;
	logic modclk_reg, modclk_next;
	logic ready_n_reg, ready_n_next;
	logic irq_reg, irq_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	// working values of the combinational process
	logic fire, wr_fire, rd_fire, rd_ok, rdy_ok, done;
	logic [2:0] grp;
	logic [CHW-1:0] idx, nxt;
	logic [NCH-1:0] rdy_clr, rdy_set, en_mask;
	logic [1:0] ev;
	logic [CW-1:0] lim;
	logic [ACCW-1:0] nticks;
	logic [ACCW:0] sum;
	logic [DW-1:0] result;
	acs_setup_t cs;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign mux = mux_reg;
	assign mod_clk = modclk_reg;
	assign ready_n = ready_n_reg;
	assign irq = irq_reg;

	// bus decode, sequencer, flags and pins: next values
	always_comb begin
		grp = paddr[7:5];
		idx = paddr[4:2];
		fire = psel & penable & pready_reg;
		wr_fire = fire & pwrite & ~pslverr_reg;
		rd_fire = fire & ~pwrite & ~pslverr_reg;
		mode_next = mode_reg;
		sel_ch_next = sel_ch_reg;
		rall_next = rall_reg;
		setup_next = setup_reg;
		offs_next = offs_reg;
		data_next = data_reg;
		irqmask_next = irqmask_reg;
		state_next = state_reg;
		cnt_next = cnt_reg + 16'h0001;
		cur_next = cur_reg;
		acc_next = acc_reg;
		acc1_next = acc1_reg;
		first_next = first_reg;
		modclk_next = 1'b0;
		rdy_clr = '0;
		rdy_set = '0;
		ev = '0;
		en_mask = '0;
		for (int i = 0; i < NCH; i++) begin
			en_mask[i] = setup_reg[i].en;
		end
		// register read data, answered one cycle into the access phase
		pready_next = psel & penable & ~pready_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		rd_ok = 1'b1;
		prdata_next = '0;
		case (grp)
			G_CTRL: begin
				case (paddr[4:0])
					A_MODE: prdata_next = (32'(sel_ch_reg) << MODE_CH_LSB) | 32'(mode_reg);
					A_IOPORT: prdata_next = 32'(rall_reg);
					A_ADCSTAT: prdata_next = 32'(rdy_reg);
					A_IRQSTAT: prdata_next = 32'(irqst_reg);
					A_IRQMASK: prdata_next = 32'(irqmask_reg);
					default: rd_ok = 1'b0;
				endcase
			end
			G_SETUP: prdata_next = (32'(setup_reg[idx].fw) << SU_FW_LSB) | (32'(setup_reg[idx].chop) << SU_CHOP)
				| (32'(setup_reg[idx].diff) << SU_DIFF) | (32'(setup_reg[idx].en) << SU_EN);
			G_OFFS: prdata_next = 32'(offs_reg[idx]);
			G_DATA: prdata_next = 32'(data_reg[idx]);
			G_CHSTAT: prdata_next = (32'(rdy_reg[idx]) << CHST_RDY) | 32'(idx);
			default: rd_ok = 1'b0;
		endcase
		if (!pready_next) begin
			prdata_next = prdata_reg;
		end
		pslverr_next = pready_next & ~rd_ok;
		// reading a data register releases its ready bit
		if (rd_fire && grp == G_DATA) begin
			rdy_clr[idx] = 1'b1;
		end
		// sequencer
		cs = setup_reg[cur_reg];
		nticks = ACCW'(cs.fw) << FW_TICK_SHIFT;
		sum = (ACCW+1)'(acc1_reg) + (ACCW+1)'(nticks - acc_reg);
		result = cs.chop ? DW'(sum >> 1) : DW'(acc1_reg);
		result = result - offs_reg[cur_reg];
		nxt = cur_reg;
		for (int k = NCH - 1; k >= 1; k--) begin
			if (setup_reg[CHW'(cur_reg + CHW'(k))].en) begin
				nxt = CHW'(cur_reg + CHW'(k));
			end
		end
		case (state_reg)
			ST_SETTLE1: lim = first_reg ? SETTLE1_LONG : SETTLE1_SHORT;
			ST_SAMPLE1, ST_SAMPLE2: lim = CW'(nticks) << MOD_DIV_SHIFT;
			ST_SETTLE2: lim = SETTLE2_CYC;
			ST_SCALE: lim = SCALE_CYC;
			default: lim = '0;
		endcase
		done = (cnt_reg + 16'h0001) >= lim;
		case (state_reg)
			ST_IDLE: begin
				cnt_next = '0;
			end
			ST_SETTLE1: begin
				if (done) begin
					state_next = ST_SAMPLE1;
					cnt_next = '0;
					acc_next = '0;
				end
			end
			ST_SAMPLE1, ST_SAMPLE2: begin
				modclk_next = ~modclk_reg;
				if (modclk_reg) begin
					acc_next = acc_reg + ACCW'(mod_bit);
				end
				if (done) begin
					cnt_next = '0;
					modclk_next = 1'b0;
					if (state_reg == ST_SAMPLE1) begin
						acc1_next = acc_next;
						state_next = cs.chop ? ST_SETTLE2 : ST_SCALE;
					end else begin
						state_next = ST_SCALE;
					end
				end
			end
			ST_SETTLE2: begin
				if (done) begin
					state_next = ST_SAMPLE2;
					cnt_next = '0;
					acc_next = '0;
				end
			end
			ST_SCALE: begin
				if (done) begin
					data_next[cur_reg] = result;
					rdy_set[cur_reg] = 1'b1;
					ev[IRQ_DONE] = 1'b1;
					ev[IRQ_OVWR] = rdy_reg[cur_reg] & ~rdy_clr[cur_reg];
					cnt_next = '0;
					first_next = 1'b0;
					if (mode_reg == MODE_CONT) begin
						cur_next = nxt;
						state_next = ST_SETTLE1;
					end else begin
						mode_next = MODE_IDLE;
						state_next = ST_IDLE;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = '0;
			end
		endcase
		// register writes; a mode write restarts the sequencer
		if (wr_fire) begin
			case (grp)
				G_CTRL: begin
					case (paddr[4:0])
						A_MODE: begin
							mode_next = pwdata[1:0];
							sel_ch_next = pwdata[MODE_CH_LSB +: CHW];
							rdy_clr = '1;
							cur_next = pwdata[MODE_CH_LSB +: CHW];
							cnt_next = '0;
							first_next = 1'b1;
							modclk_next = 1'b0;
							if (pwdata[1:0] == MODE_CONT || pwdata[1:0] == MODE_SINGLE) begin
								state_next = ST_SETTLE1;
							end else begin
								mode_next = MODE_IDLE;
								state_next = ST_IDLE;
							end
						end
						A_IOPORT: rall_next = pwdata[0];
						A_IRQMASK: irqmask_next = pwdata[1:0];
						default: ;
					endcase
				end
				G_SETUP: begin
					setup_next[idx].fw = pwdata[SU_FW_LSB +: FWW];
					setup_next[idx].chop = pwdata[SU_CHOP];
					setup_next[idx].diff = pwdata[SU_DIFF];
					setup_next[idx].en = pwdata[SU_EN];
				end
				G_OFFS: offs_next[idx] = pwdata[DW-1:0];
				default: ;
			endcase
		end
		// sticky flags: a set in the clearing cycle wins
		rdy_next = (rdy_reg & ~rdy_clr) | rdy_set;
		irqst_next = irqst_reg & ~((wr_fire && grp == G_CTRL && paddr[4:0] == A_IRQSTAT) ? pwdata[1:0] : 2'h0);
		irqst_next = irqst_next | ev;
		irq_next = |(irqst_next & irqmask_next);
		// ready pin: forced high while scaling
		rdy_ok = rall_next ? ((en_mask != '0) && ((rdy_next & en_mask) == en_mask)) : (|rdy_next);
		ready_n_next = (state_next == ST_SCALE) | ~rdy_ok;
		// multiplexer steering
		mux_next.ch = cur_next;
		mux_next.diff = setup_next[cur_next].diff;
		mux_next.swap = (state_next == ST_SETTLE2) || (state_next == ST_SAMPLE2);
		mux_next.sampling = (state_next == ST_SAMPLE1) || (state_next == ST_SAMPLE2);
	end

	// all state registers, frozen while ce is low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= MODE_IDLE;
			sel_ch_reg <= '0;
			rall_reg <= 1'b0;
			setup_reg <= '{default: '0};
			offs_reg <= '{default: '0};
			data_reg <= '{default: '0};
			rdy_reg <= '0;
			irqst_reg <= '0;
			irqmask_reg <= '0;
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			cur_reg <= '0;
			acc_reg <= '0;
			acc1_reg <= '0;
			first_reg <= 1'b1;
			mux_reg <= '0;
			modclk_reg <= 1'b0;
			ready_n_reg <= 1'b1;
			irq_reg <= 1'b0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			mode_reg <= mode_next;
			sel_ch_reg <= sel_ch_next;
			rall_reg <= rall_next;
			setup_reg <= setup_next;
			offs_reg <= offs_next;
			data_reg <= data_next;
			rdy_reg <= rdy_next;
			irqst_reg <= irqst_next;
			irqmask_reg <= irqmask_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cur_reg <= cur_next;
			acc_reg <= acc_next;
			acc1_reg <= acc1_next;
			first_reg <= first_next;
			mux_reg <= mux_next;
			modclk_reg <= modclk_next;
			ready_n_reg <= ready_n_next;
			irq_reg <= irq_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end
endmodule // acs_sequencer

/* test/acs_seq_properties.sv */
// Purpose: port-level checks of the conversion sequencer
// Assumes: one clock domain, ce low only in a first settle with the bus idle
// Notes: idle_reg counts cycles since sampling last ran
`timescale 1ns/1ps
module acs_seq_properties
	import acs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire acs_pkg::acs_mux_t mux,
	input wire logic mod_clk,
	input wire logic ready_n
);
	logic [8:0] idle_reg;
	logic [8:0] idle_next;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// saturating run length of non-sampling cycles
	always_comb begin
		idle_next = mux.sampling ? 9'h000 : ((idle_reg == 9'h1FF) ? idle_reg : idle_reg + 9'h001);
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			idle_reg <= 9'h000;
		else
			idle_reg <= idle_next;
	end
	sequence s_access;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence
	sequence s_scale;
		!mux.sampling && ready_n;
	endsequence
	a_first_settle: assert property ($rose(mux.sampling) && !mux.swap |-> idle_reg >= 9'h02B)
		else $error("first settle too short");
	a_second_settle: assert property ($rose(mux.sampling) && mux.swap |-> idle_reg == 9'h02A)
		else $error("second settle not 42 cycles");
	a_swap_after_sample: assert property ($rose(mux.swap) |-> $past(mux.sampling) && !mux.sampling)
		else $error("swap outside phase gap");
	a_first_normal: assert property ($rose(mux.sampling) && idle_reg != 9'h02A |-> !mux.swap)
		else $error("first phase reversed");
	a_scale_ready_high: assert property ($fell(mux.sampling) && !mux.swap |-> s_scale [*8])
		else $error("ready pin low in scaling");
	// a register write may also lower the pin, so falls right after a bus answer are left out
	a_scale_length: assert property ($fell(ready_n) && !$past(pready) |-> $past(mux.sampling, 164) && !$past(mux.sampling, 163))
		else $error("scaling not 163 cycles");
	a_mod_half_rate: assert property (mux.sampling && $past(mux.sampling) |-> mod_clk != $past(mod_clk))
		else $error("modulator clock not toggling");
	a_mod_idle_low: assert property (!mux.sampling |-> !mod_clk)
		else $error("modulator clock outside sampling");
	a_apb_one_wait: assert property ($rose(penable) && psel |-> s_access)
		else $error("bus answer not after one wait");
	a_err_qualified: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule // acs_seq_properties
bind acs_sequencer acs_seq_properties u_props (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .mux(mux), .mod_clk(mod_clk), .ready_n(ready_n));

/* test/acs_mod_model.sv */
// Purpose: modulator bitstream source for the sequencer
// Assumes: level per input polarity set by the bench
// Notes: outside sampling the stream toggles every cycle; reversed input gives ones on every second tick
`timescale 1ns/1ps
module acs_mod_model
	import acs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire acs_pkg::acs_mux_t mux,
	input wire logic mod_clk,
	input wire logic lvl_norm,
	input wire logic lvl_rev,
	output logic mod_bit
);
	logic tog_reg;
	logic tog_next;
	logic half_reg;
	logic half_next;
	// free toggle so stale levels are never mistaken for data; half flips once per modulator tick
	always_comb begin
		tog_next = ~tog_reg;
		half_next = half_reg ^ mod_clk;
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tog_reg <= 1'h0;
			half_reg <= 1'h0;
		end else begin
			tog_reg <= tog_next;
			half_reg <= half_next;
		end
	end
	// unequal phase results, so a mean is told apart from either phase alone
	always_comb begin
		mod_bit = mux.sampling ? (mux.swap ? (lvl_rev & half_reg) : lvl_norm) : tog_reg;
	end
endmodule // acs_mod_model

/* test/adc_conversion_sequencer_bench.sv */
// Purpose: self-checking bench of the conversion sequencer
// Assumes: APB master tasks, modulator model on mod_bit
// Notes: cycle counts sampled 1 ns after each edge
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
	import acs_pkg::*;
	logic clk_sys = 1'h0;
	logic rstn = 1'h0;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic mod_bit;
	logic mod_clk;
	logic ready_n;
	logic irq;
	acs_mux_t mux;
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	logic [31:0] q;
	logic e;
	// main clock
	always #4 clk_sys = ~clk_sys;
	acs_sequencer dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mod_bit(mod_bit), .mux(mux), .mod_clk(mod_clk), .ready_n(ready_n), .irq(irq));
	acs_mod_model u_mod (.clk_sys(clk_sys), .rstn(rstn), .mux(mux), .mod_clk(mod_clk), .lvl_norm(1'h1),
		.lvl_rev(1'h1), .mod_bit(mod_bit));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'h1 && i < 16);
		if (i >= 16) begin
			n_mismatch++;
			give_verdict();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'h0, 32'h0);
		chk(q, exp);
	endtask
	// counts cycles while sampling (k=0) or ready pin (k=1) holds lvl
	task automatic cnt(input bit k, input logic lvl);
		n = 0;
		while (((k ? ready_n : mux.sampling) === lvl) && n < 1000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 1000) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'h1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h40, 32'h0);
		xfer(8'h14, 1'h0, 32'h0);
		chk(32'(e), 32'h1);
		chk(q, 32'h0);
		$display("test reset and map done");
		xfer(8'h40, 1'h1, 32'h101);
		xfer(8'h00, 1'h1, 32'h2);
		#1;
		cnt(0, 1'h0);
		chk(n, 32'h2C);
		chk(32'(mux.swap), 32'h0);
		cnt(0, 1'h1);
		chk(n, 32'h20);
		cnt(1, 1'h1);
		chk(n, 32'hA3);
		chk(32'(ready_n), 32'h0);
		rd(8'h08, 32'h1);
		rd(8'hA0, 32'h8);
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h1);
		chk(32'(irq), 32'h0);
		xfer(8'h10, 1'h1, 32'h1);
		#1;
		chk(32'(irq), 32'h1);
		rd(8'h80, 32'h10);
		#1;
		chk(32'(ready_n), 32'h1);
		rd(8'h08, 32'h0);
		xfer(8'h0C, 1'h1, 32'h1);
		#1;
		chk(32'(irq), 32'h0);
		$display("test single done");
		xfer(8'h44, 1'h1, 32'h205);
		xfer(8'h4C, 1'h1, 32'h103);
		xfer(8'h6C, 1'h1, 32'h3);
		xfer(8'h40, 1'h1, 32'h0);
		xfer(8'h00, 1'h1, 32'h11);
		// freeze the first settle for four cycles: it must stretch by exactly that much
		@(posedge clk_sys);
		ce <= 1'h0;
		repeat (4) @(posedge clk_sys);
		ce <= 1'h1;
		#1;
		cnt(0, 1'h0);
		// 44 settle cycles plus 4 frozen, less the 5 edges already passed
		chk(n, 32'h2B);
		chk(32'(mux.ch), 32'h1);
		chk(32'(mux.swap), 32'h0);
		cnt(0, 1'h1);
		chk(n, 32'h40);
		chk(32'(mux.swap), 32'h1);
		cnt(0, 1'h0);
		chk(n, 32'h2A);
		chk(32'(mux.swap), 32'h1);
		cnt(0, 1'h1);
		chk(n, 32'h40);
		cnt(0, 1'h0);
		chk(n, 32'hCE);
		chk(32'(mux.ch), 32'h3);
		chk(32'(mux.diff), 32'h1);
		cnt(0, 1'h1);
		chk(n, 32'h20);
		cnt(1, 1'h1);
		chk(n, 32'hA3);
		rd(8'h08, 32'hA);
		rd(8'h84, 32'h18);
		rd(8'h8C, 32'hD);
		xfer(8'h04, 1'h1, 32'h1);
		#1;
		cnt(1, 1'h1);
		rd(8'h08, 32'hA);
		xfer(8'h00, 1'h1, 32'h0);
		rd(8'h00, 32'h0);
		$display("test continuous done");
		give_verdict();
	end
endmodule // adc_conversion_sequencer_bench
